// File: sicr_exc_if.sv
// exception event carrier between the register bank and the vector unit
`timescale 1ns/1ns
`default_nettype none
interface sicr_exc_if;
	logic        normal_exc;   // exception class that loads the exception pc
	logic        error_exc;    // reset, soft reset, nmi, cache error
	logic        debug_exc;    // any debug exception
	logic        boot_vector_select;
	logic [31:0] exception_vector_base;
	logic [31:0] vector_base;
	modport bank (output normal_exc, output error_exc, output debug_exc,
		output boot_vector_select, output exception_vector_base, input vector_base);
	modport unit (input normal_exc, input error_exc, input debug_exc,
		input boot_vector_select, input exception_vector_base, output vector_base);
endinterface : sicr_exc_if
`default_nettype wire

// File: sicr_pkg.sv
// shared constants for the system-control identity and configuration registers
package sicr_pkg;
	// register selection: register number and select index
	localparam logic [4:0] SICR_REGNUM_NEPC   = 5'h0e;
	localparam logic [2:0] SICR_SEL_NEPC      = 3'h2;
	localparam logic [4:0] SICR_REGNUM_ID     = 5'h0f;
	localparam logic [2:0] SICR_SEL_ID        = 3'h0;
	localparam logic [2:0] SICR_SEL_VBASE     = 3'h1;
	localparam logic [2:0] SICR_SEL_DMAP      = 3'h2;
	localparam logic [4:0] SICR_REGNUM_CONFIG = 5'h10;
	localparam logic [2:0] SICR_SEL_CONFIG    = 3'h0;
	// identity fields (values arbitrary, neutral)
	localparam logic [7:0] SICR_MAKER_OPT     = 8'h00;
	localparam logic [7:0] SICR_MAKER_CODE    = 8'h5a;
	localparam logic [7:0] SICR_PART_CODE     = 8'h3c;
	localparam logic [2:0] SICR_REV_MAJOR     = 3'h2;
	localparam logic [2:0] SICR_REV_MINOR     = 3'h1;
	localparam logic [1:0] SICR_REV_PATCH     = 2'h1;
	// exception base
	localparam logic [1:0]  SICR_VBASE_TOP    = 2'h2;
	localparam logic [17:0] SICR_VBASE_RST    = 18'h00000;
	localparam logic [31:0] SICR_BOOT_VECTOR  = 32'hbfc00000;
	localparam logic [31:0] SICR_DEBUG_VECTOR = 32'hbfc00480;
	// device map base
	localparam int          SICR_PA_BITS      = 36;
	localparam logic [20:0] SICR_DMAP_ADDR_MASK = 21'h1fffff;
	localparam logic [8:0]  SICR_DMAP_BLOCKS  = 9'h01f;
	localparam logic        SICR_DMAP_CTRL_BLK = 1'b0;
	localparam logic        SICR_DMAP_PRESENT = 1'b1;
	localparam int          SICR_DMAP_EN_BIT  = 10;
	// configuration
	localparam logic        SICR_FIXED_MAP    = 1'b1;
	localparam logic [2:0]  SICR_CCA_RST_FM   = 3'h2;
	localparam logic [2:0]  SICR_CCA_RST_TLB  = 3'h0;
	localparam logic [1:0]  SICR_ISA_TYPE     = 2'h0;
	localparam logic [2:0]  SICR_ISA_GEN      = 3'h2;
	localparam logic [2:0]  SICR_MMU_TYPE     = 3'h3;
	// remaining low configuration fields outside this block
	localparam logic [9:0]  SICR_CFG_LOW      = 10'h000;
	localparam logic [2:0]  SICR_UNMAP_CCA_RST = 3'h2;
endpackage : sicr_pkg

// File: sicr_regs.sv
// system-control identity, exception base, device map and configuration registers
`timescale 1ns/1ns
`default_nettype none
// Function
// - nested exception pc captures faulting address on every normal exception without a same-cycle error-class or debug exception, ignoring level flag
// - nested exception pc holds on error-class and debug exceptions
// - processor identity is a read-only word: options, maker, part, revision
// - revision byte splits into major, minor and patch presets
// - with boot select clear, vector base is base bits 31:12 plus zeros
// - boot select set or debug exception uses fixed default vectors
// - exception base resets to 0x80000000 with programmable field zero
// - base bits 31:30 fixed at binary 10, writes ignored
// - cpu index bits 9:0 mirror static pins, bits 11:10 read zero
// - device map base gives a 36-bit physical base, present when capability set
// - bits 31:11 hold address 35:15, unimplemented bits read zero
// - enable bit 10 resets clear and routes region accesses to device map
// - read-only bit 9 flags the control block reservation
// - bits 8:0 report implemented block count minus one
// - segment cacheability fields writable in fixed-map variant, reserved otherwise
// - bits 24 and 23 mirror the scratchpad presence pins
// - bits 18:17 mirror the write-merge pins
// - bit 15 mirrors endian pin, bit 16 reads zero
// - isa type 00, generation 010, user insn and muldiv bits zero
// - nested pc read/write combines with the instruction-set mode bit
// - return instructions never use the nested exception pc
module sicr_regs
	import sicr_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RESET_N_I,
	input  wire logic [4:0]  MOVE_REGNUM_I,
	input  wire logic [2:0]  MOVE_SEL_I,
	input  wire logic        MOVE_WRITE_I,
	input  wire logic [31:0] MOVE_WDATA_I,
	output logic [31:0]      MOVE_RDATA_O,
	output logic             MOVE_HIT_O,
	input  wire logic        NORMAL_EXC_I,
	input  wire logic        ERROR_EXC_I,
	input  wire logic        DEBUG_EXC_I,
	input  wire logic [31:0] FAULT_PC_I,
	input  wire logic        FAULT_ISA_MODE_I,
	input  wire logic        EXCEPTION_LEVEL_FLAG_I,
	input  wire logic        BOOT_VECTOR_SELECT_I,
	input  wire logic [9:0]  CPU_INDEX_PINS_I,
	input  wire logic        INSN_SCRATCHPAD_PIN_I,
	input  wire logic        DATA_SCRATCHPAD_PIN_I,
	input  wire logic [1:0]  MERGE_MODE_PINS_I,
	input  wire logic        ENDIAN_PIN_I,
	input  wire logic [35:0] PHYS_ADDR_I,
	output logic             DEVICE_MAP_SELECT_O,
	output logic [31:0]      VECTOR_BASE_O,
	output logic [1:0]       HIGH_KERNEL_SEG_CACHEABILITY_O,
	output logic [2:0]       USER_SEG_CACHEABILITY_O
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// static pins still pass three flops; the value counts once stages two and three agree
	localparam int PIN_W = 15;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1_reg;
	logic [PIN_W-1:0] pin_s2_reg;
	logic [PIN_W-1:0] pin_s3_reg;
	logic [PIN_W-1:0] pin_val_reg;
	logic [PIN_W-1:0] pin_val_next;

	assign pin_raw = {CPU_INDEX_PINS_I, INSN_SCRATCHPAD_PIN_I, DATA_SCRATCHPAD_PIN_I,
		MERGE_MODE_PINS_I, ENDIAN_PIN_I};

	genvar g;
	generate
		for (g = 0; g < PIN_W; g++) begin : g_pin
			assign pin_val_next[g] = (pin_s2_reg[g] == pin_s3_reg[g]) ? pin_s3_reg[g] : pin_val_reg[g];
		end
	endgenerate

	// synchroniser chain and filtered value
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pin_s1_reg  <= '0;
			pin_s2_reg  <= '0;
			pin_s3_reg  <= '0;
			pin_val_reg <= '0;
		end else begin
			pin_s1_reg  <= pin_raw;
			pin_s2_reg  <= pin_s1_reg;
			pin_s3_reg  <= pin_s2_reg;
			pin_val_reg <= pin_val_next;
		end
	end

	logic [9:0] cpu_index;
	logic       insn_scratchpad_present;
	logic       data_scratchpad_present;
	logic [1:0] write_merge_mode;
	logic       endian_flag;
	assign cpu_index               = pin_val_reg[14:5];
	assign insn_scratchpad_present = pin_val_reg[4];
	assign data_scratchpad_present = pin_val_reg[3];
	assign write_merge_mode        = pin_val_reg[2:1];
	assign endian_flag             = pin_val_reg[0];

	// ----------------------------------------
	// register selection
	// ----------------------------------------
	function automatic logic sel_is(input logic [4:0] rn, input logic [2:0] sl,
		input logic [4:0] want_rn, input logic [2:0] want_sl);
		sel_is = (rn == want_rn) && (sl == want_sl);
	endfunction : sel_is

	logic hit_nepc;
	logic hit_id;
	logic hit_vbr;
	logic hit_dmap;
	logic hit_cfg;
	assign hit_nepc  = sel_is(MOVE_REGNUM_I, MOVE_SEL_I, SICR_REGNUM_NEPC, SICR_SEL_NEPC);
	assign hit_id    = sel_is(MOVE_REGNUM_I, MOVE_SEL_I, SICR_REGNUM_ID, SICR_SEL_ID);
	assign hit_vbr   = sel_is(MOVE_REGNUM_I, MOVE_SEL_I, SICR_REGNUM_ID, SICR_SEL_VBASE);
	assign hit_dmap  = SICR_DMAP_PRESENT &&
		sel_is(MOVE_REGNUM_I, MOVE_SEL_I, SICR_REGNUM_ID, SICR_SEL_DMAP);
	assign hit_cfg   = sel_is(MOVE_REGNUM_I, MOVE_SEL_I, SICR_REGNUM_CONFIG, SICR_SEL_CONFIG);

	// configuration writes only land in the fixed-map variant; elsewhere the fields are reserved
	logic wr_nepc;
	logic wr_vbr;
	logic wr_dmap;
	logic wr_cfg;
	assign wr_nepc  = MOVE_WRITE_I && hit_nepc;
	assign wr_vbr   = MOVE_WRITE_I && hit_vbr;
	assign wr_dmap  = MOVE_WRITE_I && hit_dmap;
	assign wr_cfg   = MOVE_WRITE_I && hit_cfg && SICR_FIXED_MAP;

	// ----------------------------------------
	// nested exception pc
	// ----------------------------------------
	// held as pc[31:1] plus its own isa mode bit; exception return logic never reads it
	logic [30:0] nepc_reg;
	logic [30:0] nepc_next;
	logic        nepc_mode_reg;
	logic        nepc_mode_next;

	// the exception wins over a same-cycle software write so a fault is never lost
	assign nepc_next = (NORMAL_EXC_I && !ERROR_EXC_I && !DEBUG_EXC_I) ? FAULT_PC_I[31:1] :
		wr_nepc ? MOVE_WDATA_I[31:1] : nepc_reg;
	assign nepc_mode_next = (NORMAL_EXC_I && !ERROR_EXC_I && !DEBUG_EXC_I) ? FAULT_ISA_MODE_I :
		wr_nepc ? MOVE_WDATA_I[0] : nepc_mode_reg;

	// exception level flag deliberately not consulted here
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			nepc_reg      <= '0;
			nepc_mode_reg <= 1'b0;
		end else begin
			nepc_reg      <= nepc_next;
			nepc_mode_reg <= nepc_mode_next;
		end
	end

	// ----------------------------------------
	// exception vector base
	// ----------------------------------------
	// top two bits are constants, so the base can never leave the unmapped kernel window
	logic [17:0] vbr_reg;
	logic [17:0] vbr_next;
	logic [31:0] vbr_word;
	assign vbr_next = wr_vbr ? MOVE_WDATA_I[29:12] : vbr_reg;       // top bits never written
	assign vbr_word = {SICR_VBASE_TOP, vbr_reg, 2'h0, cpu_index};

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			vbr_reg <= SICR_VBASE_RST;
		end else begin
			vbr_reg <= vbr_next;
		end
	end

	// ----------------------------------------
	// device map base
	// ----------------------------------------
	// upper address bits beyond the implemented width are masked off on write
	logic [20:0] dmap_addr_reg;
	logic [20:0] dmap_addr_next;
	logic        dmap_en_reg;
	logic        dmap_en_next;
	logic [31:0] dmap_word;
	assign dmap_addr_next = wr_dmap ? (MOVE_WDATA_I[31:11] & SICR_DMAP_ADDR_MASK) : dmap_addr_reg;
	// enable resets clear, so the region stays with system memory until software opts in
	assign dmap_en_next   = wr_dmap ? MOVE_WDATA_I[SICR_DMAP_EN_BIT] : dmap_en_reg;
	assign dmap_word = SICR_DMAP_PRESENT ?
		{dmap_addr_reg, dmap_en_reg, SICR_DMAP_CTRL_BLK, SICR_DMAP_BLOCKS} : 32'h00000000;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			dmap_addr_reg <= '0;
			dmap_en_reg   <= 1'b0;
		end else begin
			dmap_addr_reg <= dmap_addr_next;
			dmap_en_reg   <= dmap_en_next;
		end
	end

	// region decode: size is block count times 64 bytes from the programmed base
	logic [35:0] dmap_base_pa;
	logic [35:0] dmap_limit_pa;
	assign dmap_base_pa  = {dmap_addr_reg, 15'h0000};
	assign dmap_limit_pa = dmap_base_pa + {21'h000000, SICR_DMAP_BLOCKS, 6'h3f};
	assign DEVICE_MAP_SELECT_O = SICR_DMAP_PRESENT && dmap_en_reg &&
		(PHYS_ADDR_I >= dmap_base_pa) && (PHYS_ADDR_I <= dmap_limit_pa);

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	logic [2:0]  hks_cca_reg;
	logic [2:0]  hks_cca_next;
	logic [2:0]  usr_cca_reg;
	logic [2:0]  usr_cca_next;
	logic [31:0] cfg_word;
	// only the fixed-map variant accepts writes; the tlb variant keeps reserved zeros
	assign hks_cca_next = wr_cfg ? MOVE_WDATA_I[30:28] : hks_cca_reg;
	assign usr_cca_next = wr_cfg ? MOVE_WDATA_I[27:25] : usr_cca_reg;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			hks_cca_reg <= SICR_FIXED_MAP ? SICR_CCA_RST_FM : SICR_CCA_RST_TLB;
			usr_cca_reg <= SICR_FIXED_MAP ? SICR_CCA_RST_FM : SICR_CCA_RST_TLB;
		end else begin
			hks_cca_reg <= hks_cca_next;
			usr_cca_reg <= usr_cca_next;
		end
	end

	// bit 31 flags the next configuration word; the low fields are presets owned elsewhere
	assign cfg_word = {1'b1, hks_cca_reg, usr_cca_reg,
		insn_scratchpad_present, data_scratchpad_present,
		1'b0, 1'b0, 1'b0, 1'b0,                           // user insn, muldiv type zero
		write_merge_mode,
		1'b0, endian_flag,
		SICR_ISA_TYPE, SICR_ISA_GEN,
		SICR_MMU_TYPE, 3'h0, 1'b0, SICR_UNMAP_CCA_RST};

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [31:0] id_word;
	assign id_word = {SICR_MAKER_OPT, SICR_MAKER_CODE, SICR_PART_CODE,
		SICR_REV_MAJOR, SICR_REV_MINOR, SICR_REV_PATCH};

	// unmapped selects fall through to zero, and the hit flag stays low for them
	logic [31:0] rdata_next;
	assign rdata_next = hit_nepc ? {nepc_reg, nepc_mode_reg} :
		hit_id    ? id_word :
		hit_vbr   ? vbr_word :
		hit_dmap  ? dmap_word :
		hit_cfg   ? cfg_word : 32'h00000000;

	logic [31:0] rdata_reg;
	logic        hit_reg;
	// read data registered: answer one edge after the move is presented
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rdata_reg <= '0;
			hit_reg   <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			hit_reg   <= hit_nepc | hit_id | hit_vbr | hit_dmap | hit_cfg;
		end
	end
	assign MOVE_RDATA_O = rdata_reg;
	assign MOVE_HIT_O   = hit_reg;

	// the high-kernel port is two bits wide, so only the low bits of that field leave the block
	assign HIGH_KERNEL_SEG_CACHEABILITY_O = hks_cca_reg[1:0];
	assign USER_SEG_CACHEABILITY_O        = usr_cca_reg;

	// ----------------------------------------
	// vector unit
	// ----------------------------------------
	// exception lines pass through the carrier so the selector sees them in the same cycle
	sicr_exc_if exc ();
	assign exc.normal_exc            = NORMAL_EXC_I;
	assign exc.error_exc             = ERROR_EXC_I;
	assign exc.debug_exc             = DEBUG_EXC_I;
	assign exc.boot_vector_select    = BOOT_VECTOR_SELECT_I;
	assign exc.exception_vector_base = vbr_word;

	sicr_vector_sel u_vector_sel (
		.CLK_I     (CLK_I),
		.RESET_N_I (RESET_N_I),
		.exc       (exc.unit)
	);
	assign VECTOR_BASE_O = exc.vector_base;

	// the level flag is a port only so that capture can be shown not to depend on it
	logic unused_level;
	assign unused_level = EXCEPTION_LEVEL_FLAG_I;
endmodule : sicr_regs
`default_nettype wire

// File: sicr_regs_assertions.sv
// port-level properties of the system-control register bank
`timescale 1ns/1ns
`default_nettype none
module sicr_regs_assertions
	import sicr_pkg::*;
(
	input wire logic        CLK_I,
	input wire logic        RESET_N_I,
	input wire logic [4:0]  MOVE_REGNUM_I,
	input wire logic [2:0]  MOVE_SEL_I,
	input wire logic        MOVE_WRITE_I,
	input wire logic [31:0] MOVE_RDATA_O,
	input wire logic        MOVE_HIT_O,
	input wire logic        NORMAL_EXC_I,
	input wire logic        ERROR_EXC_I,
	input wire logic        DEBUG_EXC_I,
	input wire logic [31:0] FAULT_PC_I,
	input wire logic        FAULT_ISA_MODE_I,
	input wire logic        BOOT_VECTOR_SELECT_I,
	input wire logic [9:0]  CPU_INDEX_PINS_I,
	input wire logic        INSN_SCRATCHPAD_PIN_I,
	input wire logic        DATA_SCRATCHPAD_PIN_I,
	input wire logic [1:0]  MERGE_MODE_PINS_I,
	input wire logic        ENDIAN_PIN_I,
	input wire logic [31:0] VECTOR_BASE_O
);
	// ----------------------------------------
	// select decode and helpers
	// ----------------------------------------
	wire logic sel_nepc = MOVE_REGNUM_I == SICR_REGNUM_NEPC && MOVE_SEL_I == SICR_SEL_NEPC;
	wire logic sel_id   = MOVE_REGNUM_I == SICR_REGNUM_ID && MOVE_SEL_I == SICR_SEL_ID;
	wire logic sel_eb   = MOVE_REGNUM_I == SICR_REGNUM_ID && MOVE_SEL_I == SICR_SEL_VBASE;
	wire logic sel_dm   = MOVE_REGNUM_I == SICR_REGNUM_ID && MOVE_SEL_I == SICR_SEL_DMAP;
	wire logic sel_cf   = MOVE_REGNUM_I == SICR_REGNUM_CONFIG && MOVE_SEL_I == SICR_SEL_CONFIG;
	wire logic mapped   = sel_nepc | sel_id | sel_eb | sel_dm | sel_cf;
	logic [2:0]  age_reg;
	logic [31:0] cap_reg;
	// pins pass a 3-flop sync, so wait a few edges after reset before judging
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			age_reg <= 3'h0;
		end else if (age_reg != 3'h7) begin
			age_reg <= age_reg + 3'h1;
		end
	end
	// last faulting address in read form
	always_ff @(posedge CLK_I) begin
		if (NORMAL_EXC_I && !ERROR_EXC_I && !DEBUG_EXC_I) begin
			cap_reg <= {FAULT_PC_I[31:1], FAULT_ISA_MODE_I};
		end
	end
	wire logic live = age_reg == 3'h7;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence cap_s;
		NORMAL_EXC_I && !ERROR_EXC_I && !DEBUG_EXC_I;
	endsequence
	sequence ask_s;
		sel_nepc && !NORMAL_EXC_I && !MOVE_WRITE_I;
	endsequence
	nested_capture_a: assert property (cap_s ##1 ask_s [*2] |=> MOVE_RDATA_O == cap_reg)
		else $error("nested pc does not show captured address");
	unmapped_zero_a: assert property (live && !$past(mapped) |-> MOVE_RDATA_O == 32'h0 && !MOVE_HIT_O)
		else $error("unmapped select returned data or hit");
	mapped_hit_a: assert property (live && $past(mapped) |-> MOVE_HIT_O)
		else $error("mapped select without hit");
	identity_word_a: assert property (live && $past(sel_id) |-> MOVE_RDATA_O == {SICR_MAKER_OPT,
		SICR_MAKER_CODE, SICR_PART_CODE, SICR_REV_MAJOR, SICR_REV_MINOR, SICR_REV_PATCH})
		else $error("identity word wrong");
	vbase_fixed_a: assert property (live && $past(sel_eb) |-> MOVE_RDATA_O[31:30] == 2'h2
		&& MOVE_RDATA_O[11:0] == {2'h0, CPU_INDEX_PINS_I})
		else $error("exception base fixed bits wrong");
	dmap_low_a: assert property (live && $past(sel_dm) |->
		MOVE_RDATA_O[9:0] == {SICR_DMAP_CTRL_BLK, SICR_DMAP_BLOCKS})
		else $error("device map preset bits wrong");
	cfg_fixed_a: assert property (live && $past(sel_cf) |-> MOVE_RDATA_O[22:19] == 4'h0
		&& MOVE_RDATA_O[16] == 1'b0 && MOVE_RDATA_O[14:10] == 5'h02)
		else $error("configuration constant bits wrong");
	cfg_pins_a: assert property (live && $past(sel_cf) |-> MOVE_RDATA_O[15] == ENDIAN_PIN_I
		&& MOVE_RDATA_O[24:23] == {INSN_SCRATCHPAD_PIN_I, DATA_SCRATCHPAD_PIN_I}
		&& MOVE_RDATA_O[18:17] == MERGE_MODE_PINS_I)
		else $error("configuration pin bits wrong");
	boot_vector_a: assert property (live && $past(BOOT_VECTOR_SELECT_I) && !$past(DEBUG_EXC_I)
		|-> VECTOR_BASE_O == SICR_BOOT_VECTOR)
		else $error("boot select set but vector not fixed");
	vector_align_a: assert property (live && !$past(BOOT_VECTOR_SELECT_I) && !$past(DEBUG_EXC_I)
		|-> VECTOR_BASE_O[31:30] == 2'h2 && VECTOR_BASE_O[11:0] == 12'h0)
		else $error("programmed vector base misaligned");
	debug_vector_a: assert property (live && $past(DEBUG_EXC_I) |-> VECTOR_BASE_O == SICR_DEBUG_VECTOR)
		else $error("debug exception did not use the fixed vector");
endmodule : sicr_regs_assertions
bind sicr_regs sicr_regs_assertions chk_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .MOVE_REGNUM_I(MOVE_REGNUM_I),
	.MOVE_SEL_I(MOVE_SEL_I), .MOVE_WRITE_I(MOVE_WRITE_I), .MOVE_RDATA_O(MOVE_RDATA_O), .MOVE_HIT_O(MOVE_HIT_O),
	.NORMAL_EXC_I(NORMAL_EXC_I), .ERROR_EXC_I(ERROR_EXC_I), .DEBUG_EXC_I(DEBUG_EXC_I), .FAULT_PC_I(FAULT_PC_I),
	.FAULT_ISA_MODE_I(FAULT_ISA_MODE_I), .BOOT_VECTOR_SELECT_I(BOOT_VECTOR_SELECT_I),
	.CPU_INDEX_PINS_I(CPU_INDEX_PINS_I), .INSN_SCRATCHPAD_PIN_I(INSN_SCRATCHPAD_PIN_I),
	.DATA_SCRATCHPAD_PIN_I(DATA_SCRATCHPAD_PIN_I), .MERGE_MODE_PINS_I(MERGE_MODE_PINS_I),
	.ENDIAN_PIN_I(ENDIAN_PIN_I), .VECTOR_BASE_O(VECTOR_BASE_O));
`default_nettype wire

// File: sicr_vector_sel.sv
// exception vector base selection
`timescale 1ns/1ns
`default_nettype none
module sicr_vector_sel
	import sicr_pkg::*;
(
	input  wire logic CLK_I,
	input  wire logic RESET_N_I,
	sicr_exc_if.unit  exc
);
	logic [31:0] vector_base_reg;
	logic [31:0] vector_base_next;

	// ----------------------------------------
	// base selection
	// ----------------------------------------
	// debug always uses the fixed location, boot select forces fixed defaults
	assign vector_base_next = exc.debug_exc ? SICR_DEBUG_VECTOR :
		exc.boot_vector_select ? SICR_BOOT_VECTOR :
		{exc.exception_vector_base[31:12], 12'h000};

	// registered so the fetch unit sees a clean value
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			vector_base_reg <= SICR_BOOT_VECTOR;
		end else begin
			vector_base_reg <= vector_base_next;
		end
	end

	assign exc.vector_base = vector_base_reg;
endmodule : sicr_vector_sel
`default_nettype wire

// File: testbench.sv
// self-checking bench for the system-control register bank
`timescale 1ns/1ns
`default_nettype none
module testbench
	import sicr_pkg::*;
;
	logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, hit, nexc = 1'b0, eexc = 1'b0, dexc = 1'b0;
	logic        fisa = 1'b0, lvl_flag = 1'b0, boot = 1'b1, dsel;
	logic [4:0]  regnum = 5'h0;
	logic [2:0]  sel = 3'h0, ukc;
	logic [31:0] wdata = 32'h0, fpc = 32'h0, rdata, vbase;
	logic [35:0] paddr = 36'h0;
	logic [1:0]  hkc;
	int          fails = 0, checked = 0, cycles = 0;
	localparam logic [35:0] DM_BASE = 36'h091a28000;
	always #5 clk = ~clk;
	// static pins held constant: they are synchronised and only meaningful when quiet
	sicr_regs dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .MOVE_REGNUM_I(regnum), .MOVE_SEL_I(sel),
		.MOVE_WRITE_I(wr_en), .MOVE_WDATA_I(wdata), .MOVE_RDATA_O(rdata), .MOVE_HIT_O(hit),
		.NORMAL_EXC_I(nexc), .ERROR_EXC_I(eexc), .DEBUG_EXC_I(dexc), .FAULT_PC_I(fpc), .FAULT_ISA_MODE_I(fisa),
		.EXCEPTION_LEVEL_FLAG_I(lvl_flag), .BOOT_VECTOR_SELECT_I(boot), .CPU_INDEX_PINS_I(10'h2a5),
		.INSN_SCRATCHPAD_PIN_I(1'b1), .DATA_SCRATCHPAD_PIN_I(1'b0), .MERGE_MODE_PINS_I(2'h2),
		.ENDIAN_PIN_I(1'b1), .PHYS_ADDR_I(paddr), .DEVICE_MAP_SELECT_O(dsel), .VECTOR_BASE_O(vbase),
		.HIGH_KERNEL_SEG_CACHEABILITY_O(hkc), .USER_SEG_CACHEABILITY_O(ukc));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [4:0] rn, input logic [2:0] sl, input logic [31:0] d);
		@(negedge clk);
		regnum = rn;
		sel = sl;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : wr
	// select held two edges so a write just before is visible
	task automatic rdc(input string what, input logic [4:0] rn, input logic [2:0] sl, input logic [31:0] exp,
		input logic [31:0] mask, input logic eh);
		@(negedge clk);
		regnum = rn;
		sel = sl;
		repeat (2) @(negedge clk);
		chk(what, rdata & mask, exp & mask);
		chk("hit", {31'h0, hit}, {31'h0, eh});
	endtask : rdc
	task automatic exc(input logic n, input logic e, input logic d, input logic [31:0] pc, input logic isa);
		@(negedge clk);
		{nexc, eexc, dexc, fpc, fisa} = {n, e, d, pc, isa};
		@(negedge clk);
		{nexc, eexc, dexc} = 3'h0;
	endtask : exc
	task automatic probe(input logic [35:0] a, input logic exp);
		@(negedge clk);
		paddr = a;
		#1 chk("devmap select", {31'h0, dsel}, {31'h0, exp});
	endtask : probe
	// hang guard: the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			complete_run();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		chk("vector", vbase, SICR_BOOT_VECTOR);
		rdc("vector base", SICR_REGNUM_ID, SICR_SEL_VBASE, 32'h800002a5, 32'hffffffff, 1'b1);
		rdc("devmap", SICR_REGNUM_ID, SICR_SEL_DMAP, {22'h0, SICR_DMAP_CTRL_BLK, SICR_DMAP_BLOCKS}, 32'h7ff, 1'b1);
		rdc("config", SICR_REGNUM_CONFIG, SICR_SEL_CONFIG, 32'h25048800, 32'h7ffffc00, 1'b1);
		chk("cca", {27'h0, hkc, ukc}, {27'h0, 2'h2, 3'h2});
		wr(SICR_REGNUM_ID, SICR_SEL_ID, 32'hffffffff);
		rdc("identity", SICR_REGNUM_ID, SICR_SEL_ID, {SICR_MAKER_OPT, SICR_MAKER_CODE, SICR_PART_CODE,
			SICR_REV_MAJOR, SICR_REV_MINOR, SICR_REV_PATCH}, 32'hffffffff, 1'b1);
		wr(SICR_REGNUM_CONFIG, SICR_SEL_CONFIG, 32'h56fb77ff);
		rdc("config", SICR_REGNUM_CONFIG, SICR_SEL_CONFIG, 32'h57048800, 32'h7ffffc00, 1'b1);
		chk("cca", {27'h0, hkc, ukc}, {27'h0, 2'h1, 3'h3});
		// base changed only with boot select set and bit 12 kept clear
		wr(SICR_REGNUM_ID, SICR_SEL_VBASE, 32'h7fffefff);
		rdc("vector base", SICR_REGNUM_ID, SICR_SEL_VBASE, 32'hbfffe2a5, 32'hffffffff, 1'b1);
		boot = 1'b0;
		repeat (2) @(negedge clk);
		chk("vector", vbase, 32'hbfffe000);
		dexc = 1'b1;
		@(negedge clk);
		chk("vector", vbase, SICR_DEBUG_VECTOR);
		dexc = 1'b0;
		boot = 1'b1;
		repeat (2) @(negedge clk);
		chk("vector", vbase, SICR_BOOT_VECTOR);
		wr(SICR_REGNUM_ID, SICR_SEL_DMAP, 32'h091a2fff);
		rdc("devmap", SICR_REGNUM_ID, SICR_SEL_DMAP, 32'h091a2c1f, 32'hffffffff, 1'b1);
		probe(DM_BASE, 1'b1);
		probe(DM_BASE + 36'h7ff, 1'b1);
		probe(DM_BASE + 36'h800, 1'b0);
		probe(DM_BASE - 36'h1, 1'b0);
		wr(SICR_REGNUM_ID, SICR_SEL_DMAP, 32'h091a2800);
		probe(DM_BASE, 1'b0);
		lvl_flag = 1'b1;
		exc(1'b1, 1'b0, 1'b0, 32'h80001235, 1'b0);
		rdc("nested pc", SICR_REGNUM_NEPC, SICR_SEL_NEPC, 32'h80001234, 32'hffffffff, 1'b1);
		exc(1'b0, 1'b1, 1'b0, 32'h11111111, 1'b1);
		exc(1'b0, 1'b0, 1'b1, 32'h22222222, 1'b1);
		rdc("nested pc", SICR_REGNUM_NEPC, SICR_SEL_NEPC, 32'h80001234, 32'hffffffff, 1'b1);
		wr(SICR_REGNUM_NEPC, SICR_SEL_NEPC, 32'h0000abcd);
		rdc("nested pc", SICR_REGNUM_NEPC, SICR_SEL_NEPC, 32'h0000abcd, 32'hffffffff, 1'b1);
		lvl_flag = 1'b0;
		exc(1'b1, 1'b0, 1'b0, 32'hc0000010, 1'b1);
		rdc("nested pc", SICR_REGNUM_NEPC, SICR_SEL_NEPC, 32'hc0000011, 32'hffffffff, 1'b1);
		rdc("unmapped", 5'h1f, 3'h7, 32'h0, 32'hffffffff, 1'b0);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
